//--- scmc_core.v
/*
 * scmc_core.v: operating-mode controller of the safety cpu, with its
 * avalon-mm register slave, indicators and transition side effects.
 * assumes one 20 MHz clock, pins from outside the clock domain,
 * and a tool session reached through the register port.
 */
`timescale 1ns/10ps
`include "scmc_regs.vh"

// Notes on behaviour
// R1: after self-test, enter program if application unvalidated, else run.
// R2: initializing runs self-test, run indicator flashes green, debug dark.
// R3: program mode halts comms and execution, debug dark, edits allowed.
// R4: run mode runs comms and validated programs, run lit, debug dark.
// R5: debug stopped: comms on, programs idle, run dark, debug lit, forcing.
// R6: debug running: comms on, programs run, both indicators lit, forcing.
// R7: restore: no comms, no programs, both indicators flash.
// R8: mode changes only from own commands, never from host controller mode.
// R9: forced refreshing accepted only in debug sub-states, else rejected.
// R10: entering debug needs an online tool session.
// R11: lost session in debug falls back to program after thirty seconds.
// R12: only one tool session online; a second one is refused.
// R13: init and restore: inputs not received, outputs and status cleared.
// R14: program: standard inputs off, outputs cleared, status refreshed.
// R15: run and debug: all inputs, outputs and status refreshed.
// R16: program to debug stopped starts safety process data comms.
// R17: program to run, stopped to running: init variables, restart program.
// R18: between debug sub-states comms continue without interruption.
// R19: leaving debug running to stopped or program clears forcing.
// R20: entering program stops comms and zeroes safety input/output images; entry from init skips the zeroing.
// R21: run or debug running to program: init variables, stop program.
// R22: run to program erases stored safety programs.
// R23: program to debug erases safety application data.
// R24: tool requests modes by explicit commands; mode otherwise holds.
module scmc_core #(
  parameter [29:0] TOUT_CYC = `SCMC_TOUT_CYC,
  parameter [22:0] BLINK_CYC = `SCMC_BLINK_CYC
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire tool_link_ok,
  input wire selftest_done,
  input wire app_valid,
  output wire led_run,
  output wire led_dbg,
  output wire selftest_run,
  output wire safety_comm_en,
  output wire prog_exec_en,
  output wire app_edit_en,
  output wire safe_in_recv,
  output wire std_in_recv,
  output wire out_clear,
  output wire status_clear,
  output wire status_refresh,
  output wire force_active,
  output wire var_init,
  output wire prog_restart,
  output wire force_clear,
  output wire sio_image_zero,
  output wire nvm_erase_prog,
  output wire nvm_erase_app
);

  // ***************************************************************
  // modes
  // ***************************************************************
  localparam [2:0] M_INIT = `SCMC_M_INIT;
  localparam [2:0] M_PROG = `SCMC_M_PROG;
  localparam [2:0] M_RUN = `SCMC_M_RUN;
  localparam [2:0] M_DSTOP = `SCMC_M_DSTOP;
  localparam [2:0] M_DRUN = `SCMC_M_DRUN;
  localparam [2:0] M_REST = `SCMC_M_REST;

  // debug sub-state decode
  function is_dbg;
    input [2:0] m;
    begin
      is_dbg = (m == M_DSTOP) || (m == M_DRUN);
    end
  endfunction

  // legal commanded transitions
  function cmd_ok;
    input [2:0] from;
    input [2:0] to;
    input online;
    input valid;
    begin
      case (from)
        M_PROG: cmd_ok = (to == M_RUN && valid) ||
                         (to == M_DSTOP && online) || (to == M_REST);
        M_RUN: cmd_ok = (to == M_PROG);
        M_DSTOP: cmd_ok = (to == M_DRUN) || (to == M_PROG);
        M_DRUN: cmd_ok = (to == M_DSTOP) || (to == M_PROG);
        M_REST: cmd_ok = (to == M_PROG);
        default: cmd_ok = 1'b0;
      endcase
    end
  endfunction

  // ***************************************************************
  // declarations
  // ***************************************************************
  wire link_s;
  wire stdone_s;
  wire valid_s;
  wire tout_exp;
  reg [2:0] mode_ff;
  reg [2:0] nxt_mode;
  reg valid_ff;
  reg nxt_valid;
  reg online_ff;
  reg nxt_online;
  reg [3:0] ses_id_ff;
  reg [3:0] nxt_ses_id;
  reg [2:0] cmd_ff;
  reg [2:0] nxt_cmd;
  reg sref_ff;
  reg crej_ff;
  reg frej_ff;
  reg fallb_ff;
  reg nxt_sref;
  reg nxt_crej;
  reg nxt_frej;
  reg nxt_fallb;
  reg frc_ff;
  reg nxt_frc;
  reg wait_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg [22:0] blink_cnt_ff;
  reg blink_ff;
  reg led_run_ff;
  reg led_dbg_ff;
  reg [8:0] lvl_ff;
  reg [8:0] nxt_lvl;
  reg [5:0] pls_ff;
  reg [5:0] nxt_pls;
  reg nxt_led_run;
  reg nxt_led_dbg;
  wire wr_fire;
  wire wr_cmd;
  wire wr_ses;
  wire wr_st;
  wire wr_frc;
  wire [2:0] req_mode;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  scmc_sync u_sync_link (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(tool_link_ok),
    .level_out(link_s)
  );

  scmc_sync u_sync_stdone (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(selftest_done),
    .level_out(stdone_s)
  );

  scmc_sync u_sync_valid (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_in(app_valid),
    .level_out(valid_s)
  );

  // ***************************************************************
  // avalon-mm slave
  // ***************************************************************
  assign wr_fire = avs_write && !wait_ff;
  assign wr_cmd = wr_fire && (avs_address == `SCMC_OFS_CMD);
  assign wr_ses = wr_fire && (avs_address == `SCMC_OFS_SESSION);
  assign wr_st = wr_fire && (avs_address == `SCMC_OFS_STATUS);
  assign wr_frc = wr_fire && (avs_address == `SCMC_OFS_FORCE);
  assign req_mode = avs_writedata[`SCMC_CMD_MODE_MSB:`SCMC_CMD_MODE_LSB];

  always @* begin
    nxt_rdata = 32'h0;
    case (avs_address)
      `SCMC_OFS_CMD: begin
        nxt_rdata[`SCMC_CMD_MODE_MSB:`SCMC_CMD_MODE_LSB] = cmd_ff;
      end
      `SCMC_OFS_SESSION: begin
        nxt_rdata[`SCMC_SES_OPEN_BIT] = online_ff;
        nxt_rdata[`SCMC_SES_ID_MSB:`SCMC_SES_ID_LSB] = ses_id_ff;
      end
      `SCMC_OFS_STATUS: begin
        nxt_rdata[`SCMC_ST_MODE_MSB:`SCMC_ST_MODE_LSB] = mode_ff;
        nxt_rdata[`SCMC_ST_ONLINE_BIT] = online_ff;
        nxt_rdata[`SCMC_ST_SREF_BIT] = sref_ff;
        nxt_rdata[`SCMC_ST_CREJ_BIT] = crej_ff;
        nxt_rdata[`SCMC_ST_FREJ_BIT] = frej_ff;
        nxt_rdata[`SCMC_ST_FALLB_BIT] = fallb_ff;
        nxt_rdata[`SCMC_ST_VALID_BIT] = valid_ff;
      end
      `SCMC_OFS_FORCE: begin
        nxt_rdata[`SCMC_FRC_EN_BIT] = frc_ff;
      end
      default: begin
        nxt_rdata = 32'h0;
      end
    endcase
  end

  // ***************************************************************
  // tool session
  // ***************************************************************
  always @* begin
    nxt_online = online_ff;
    nxt_ses_id = ses_id_ff;
    nxt_sref = sref_ff;
    if (wr_st && avs_writedata[`SCMC_ST_SREF_BIT]) begin
      nxt_sref = 1'b0;
    end
    if (!link_s) begin
      nxt_online = 1'b0;
    end else if (wr_ses && avs_writedata[`SCMC_SES_CLOSE_BIT]) begin
      nxt_online = 1'b0;
    end else if (wr_ses && avs_writedata[`SCMC_SES_OPEN_BIT]) begin
      // R12 single session only
      if (online_ff) begin
        nxt_sref = 1'b1;
      end else begin
        nxt_online = 1'b1;
        nxt_ses_id = avs_writedata[`SCMC_SES_ID_MSB:`SCMC_SES_ID_LSB];
      end
    end
  end

  // ***************************************************************
  // fallback timer
  // ***************************************************************
  // R11 thirty second fallback
  scmc_tmr #(
    .LIMIT(TOUT_CYC)
  ) u_tmr (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(is_dbg(mode_ff) && !online_ff),
    .expired(tout_exp)
  );

  // ***************************************************************
  // mode state machine
  // ***************************************************************
  always @* begin
    nxt_mode = mode_ff;
    nxt_valid = valid_ff;
    nxt_cmd = cmd_ff;
    nxt_crej = crej_ff;
    nxt_fallb = fallb_ff;
    if (wr_st && avs_writedata[`SCMC_ST_CREJ_BIT]) begin
      nxt_crej = 1'b0;
    end
    if (wr_st && avs_writedata[`SCMC_ST_FALLB_BIT]) begin
      nxt_fallb = 1'b0;
    end
    case (mode_ff)
      M_INIT: begin
        // R1 start mode from validation
        if (stdone_s) begin
          nxt_valid = valid_s;
          nxt_mode = valid_s ? M_RUN : M_PROG;
        end
      end
      M_PROG, M_RUN, M_DSTOP, M_DRUN, M_REST: begin
        if (is_dbg(mode_ff) && tout_exp) begin
          nxt_mode = M_PROG;
          nxt_fallb = 1'b1;
        end else if (wr_cmd) begin
          // R24 explicit commands only
          nxt_cmd = req_mode;
          // R10 debug needs session
          if (cmd_ok(mode_ff, req_mode, online_ff, valid_ff)) begin
            nxt_mode = req_mode;
          end else begin
            nxt_crej = 1'b1;
          end
        end
      end
      default: begin
        nxt_mode = M_INIT;
      end
    endcase
  end

  // ***************************************************************
  // forced refreshing
  // ***************************************************************
  always @* begin
    nxt_frc = frc_ff;
    nxt_frej = frej_ff;
    if (wr_st && avs_writedata[`SCMC_ST_FREJ_BIT]) begin
      nxt_frej = 1'b0;
    end
    if (wr_frc) begin
      // R9 forcing in debug only
      if (is_dbg(mode_ff)) begin
        nxt_frc = avs_writedata[`SCMC_FRC_EN_BIT];
      end else begin
        nxt_frej = 1'b1;
      end
    end
    // R19 forcing cleared
    if (mode_ff == M_DRUN && nxt_mode != M_DRUN) begin
      nxt_frc = 1'b0;
    end
    if (!is_dbg(nxt_mode)) begin
      nxt_frc = 1'b0;
    end
  end

  // ***************************************************************
  // per-mode levels
  // ***************************************************************
  // order: selftest comm exec edit sin stdin outclr stclr stref
  always @* begin
    case (nxt_mode)
      // R2 R13 initializing
      M_INIT: nxt_lvl = 9'b1_0000_0110;
      // R3 R14 R20 program
      M_PROG: nxt_lvl = 9'b0_0010_0101;
      // R4 R15 run
      M_RUN: nxt_lvl = 9'b0_1101_1001;
      // R5 R15 R16 R18 debug stopped
      M_DSTOP: nxt_lvl = 9'b0_1001_1001;
      // R6 R15 R18 debug running
      M_DRUN: nxt_lvl = 9'b0_1101_1001;
      // R7 R13 restore
      M_REST: nxt_lvl = 9'b0_0000_0110;
      default: nxt_lvl = 9'b1_0000_0110;
    endcase
  end

  // ***************************************************************
  // transition pulses
  // ***************************************************************
  // order: varinit restart frcclr imgzero erprog erapp
  always @* begin
    nxt_pls = 6'h00;
    if (nxt_mode != mode_ff) begin
      // R17 restart from first step
      if ((mode_ff == M_PROG && nxt_mode == M_RUN) ||
          (mode_ff == M_DSTOP && nxt_mode == M_DRUN)) begin
        nxt_pls[5] = 1'b1;
        nxt_pls[4] = 1'b1;
      end
      // R21 variables initialised on stop
      if ((mode_ff == M_RUN || mode_ff == M_DRUN) &&
          nxt_mode == M_PROG) begin
        nxt_pls[5] = 1'b1;
      end
      if (mode_ff == M_DRUN && nxt_mode == M_DSTOP) begin
        nxt_pls[5] = 1'b1;
      end
      // R19 clear forcing
      if (mode_ff == M_DRUN) begin
        nxt_pls[3] = 1'b1;
      end
      // R20 zero safety images
      if (nxt_mode == M_PROG && mode_ff != M_INIT) begin
        nxt_pls[2] = 1'b1;
      end
      // R22 erase stored programs
      if (mode_ff == M_RUN && nxt_mode == M_PROG) begin
        nxt_pls[1] = 1'b1;
      end
      // R23 erase application data
      if (mode_ff == M_PROG && is_dbg(nxt_mode)) begin
        nxt_pls[0] = 1'b1;
      end
    end
  end

  // ***************************************************************
  // indicators
  // ***************************************************************
  always @* begin
    nxt_led_run = 1'b0;
    nxt_led_dbg = 1'b0;
    case (nxt_mode)
      // R2 flashing green
      M_INIT: nxt_led_run = blink_ff;
      // R4 R6 steady green
      M_RUN, M_DRUN: nxt_led_run = 1'b1;
      default: nxt_led_run = 1'b0;
    endcase
    case (nxt_mode)
      // R5 R6 steady yellow
      M_DSTOP, M_DRUN: nxt_led_dbg = 1'b1;
      default: nxt_led_dbg = 1'b0;
    endcase
    // R7 both flashing
    if (nxt_mode == M_REST) begin
      nxt_led_run = blink_ff;
      nxt_led_dbg = blink_ff;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // R8 mode held locally only
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= `SCMC_RST_MODE;
      valid_ff <= 1'b0;
      online_ff <= 1'b0;
      ses_id_ff <= `SCMC_RST_SES_ID;
      cmd_ff <= `SCMC_RST_CMD;
      {sref_ff, crej_ff, frej_ff, fallb_ff} <= `SCMC_RST_STICKY;
      frc_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
      blink_cnt_ff <= 23'h0;
      blink_ff <= 1'b0;
      led_run_ff <= 1'b0;
      led_dbg_ff <= 1'b0;
      lvl_ff <= 9'b1_0000_0110;
      pls_ff <= 6'h00;
    end else begin
      mode_ff <= nxt_mode;
      valid_ff <= nxt_valid;
      online_ff <= nxt_online;
      ses_id_ff <= nxt_ses_id;
      cmd_ff <= nxt_cmd;
      sref_ff <= nxt_sref;
      crej_ff <= nxt_crej;
      frej_ff <= nxt_frej;
      fallb_ff <= nxt_fallb;
      frc_ff <= nxt_frc;
      wait_ff <= !((avs_read || avs_write) && wait_ff);
      rdata_ff <= nxt_rdata;
      if (blink_cnt_ff >= BLINK_CYC - 23'h1) begin
        blink_cnt_ff <= 23'h0;
        blink_ff <= !blink_ff;
      end else begin
        blink_cnt_ff <= blink_cnt_ff + 23'h1;
      end
      led_run_ff <= nxt_led_run;
      led_dbg_ff <= nxt_led_dbg;
      lvl_ff <= nxt_lvl;
      pls_ff <= nxt_pls;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign led_run = led_run_ff;
  assign led_dbg = led_dbg_ff;
  assign selftest_run = lvl_ff[8];
  assign safety_comm_en = lvl_ff[7];
  assign prog_exec_en = lvl_ff[6];
  assign app_edit_en = lvl_ff[5];
  assign safe_in_recv = lvl_ff[4];
  assign std_in_recv = lvl_ff[3];
  assign out_clear = lvl_ff[2];
  assign status_clear = lvl_ff[1];
  assign status_refresh = lvl_ff[0];
  assign force_active = frc_ff;
  assign var_init = pls_ff[5];
  assign prog_restart = pls_ff[4];
  assign force_clear = pls_ff[3];
  assign sio_image_zero = pls_ff[2];
  assign nvm_erase_prog = pls_ff[1];
  assign nvm_erase_app = pls_ff[0];

endmodule // scmc_core

//--- scmc_core_bench.sv
/* bench of the mode controller over its avalon-mm port.
   assumes the far model and the bound checker. */
`timescale 1ns/10ps
module scmc_core_bench;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic cable = 1'b0;
  logic strap = 1'b0;
  logic [31:0] d;
  wire [31:0] rdat;
  wire wrq, lnk, std, apv, lr, ld, str, cm, ex, ed, si, ti, oc, sc, sr, fa;
  wire vi, pr, fc, sz, ep, ea;
  int mismatches = 0;
  int cmp_count = 0;
  int n_ep = 0;
  int n_ea = 0;
  int n_sz = 0;
  int n_fc = 0;
  int n_pr = 0;
  int n_vi = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (ep === 1'b1) n_ep <= n_ep + 1;
    if (ea === 1'b1) n_ea <= n_ea + 1;
    if (sz === 1'b1) n_sz <= n_sz + 1;
    if (fc === 1'b1) n_fc <= n_fc + 1;
    if (pr === 1'b1) n_pr <= n_pr + 1;
    if (vi === 1'b1) n_vi <= n_vi + 1;
  end
  scmc_far far (.clk_sys(clk_sys), .arst_n(arst_n), .cable(cable),
    .strap(strap), .tool_link_ok(lnk), .selftest_done(std), .app_valid(apv));
  scmc_core #(.TOUT_CYC(30'd200), .BLINK_CYC(23'd4)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .tool_link_ok(lnk), .selftest_done(std),
    .app_valid(apv), .led_run(lr), .led_dbg(ld), .selftest_run(str),
    .safety_comm_en(cm), .prog_exec_en(ex), .app_edit_en(ed),
    .safe_in_recv(si), .std_in_recv(ti), .out_clear(oc), .status_clear(sc),
    .status_refresh(sr), .force_active(fa), .var_init(vi),
    .prog_restart(pr), .force_clear(fc), .sio_image_zero(sz),
    .nvm_erase_prog(ep), .nvm_erase_app(ea));
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] v);
    int i;
    adr <= a;
    wdat <= v;
    rd_en <= !w;
    wr_en <= w;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wrq !== 1'b0 && i < 50);
    d = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (wrq !== 1'b0) begin
      mismatches++;
      wrap_up;
    end
    @(posedge clk_sys);
  endtask
  task automatic wait_mode(logic [2:0] m, int n);
    int i;
    i = 0;
    do begin
      bus(1'b0, 5'h08, 32'h0);
      i++;
    end while (d[2:0] !== m && i < n);
    chk("mode", m, d[2:0]);
    if (d[2:0] !== m)
      wrap_up;
  endtask
  task automatic mode_cmd(logic [2:0] m);
    bus(1'b1, 5'h00, {29'h0, m});
    wait_mode(m, 10);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk("init", 4'b1011, {str, ld, oc, sc});
    wait_mode(3'h1, 40);
    chk("prog", 5'b10001, {ed, cm, ex, ti, sr});
    bus(1'b0, 5'h10, 32'h0);
    chk("unmapped", 32'h0, d);
    bus(1'b1, 5'h00, 32'h3);
    bus(1'b0, 5'h08, 32'h0);
    chk("no session", 4'h9, {d[5], d[2:0]});
    bus(1'b1, 5'h0c, 32'h1);
    bus(1'b0, 5'h08, 32'h0);
    chk("force out", 2'b10, {d[6], fa});
    bus(1'b1, 5'h08, 32'hf0);
    cable <= 1'b1;
    repeat (8) @(posedge clk_sys);
    bus(1'b1, 5'h04, 32'h11);
    bus(1'b1, 5'h04, 32'h21);
    bus(1'b0, 5'h08, 32'h0);
    chk("second", 2'b11, d[4:3]);
    bus(1'b0, 5'h04, 32'h0);
    chk("session", 8'h11, d[7:0]);
    mode_cmd(3'h3);
    chk("dstop", 5'b01101, {lr, ld, cm, ex, n_ea == 1});
    bus(1'b1, 5'h0c, 32'h1);
    chk("force", 1'b1, fa);
    mode_cmd(3'h4);
    chk("drun", 4'b1111, {lr, ld, cm, ex});
    mode_cmd(3'h3);
    chk("unforced", 2'b01, {fa, cm});
    mode_cmd(3'h4);
    mode_cmd(3'h1);
    chk("back", 3'b001, {cm, ex, oc});
    chk("pulses", 4'hf, {n_sz == 1, n_fc == 2, n_pr == 2, n_vi == 4});
    mode_cmd(3'h5);
    chk("restore", 5'b00011, {cm, ex, si, oc, sc});
    d[0] = lr;
    repeat (4) @(posedge clk_sys);
    chk("flash", 2'b11, {lr === ld, lr !== d[0]});
    mode_cmd(3'h1);
    mode_cmd(3'h3);
    cable <= 1'b0;
    repeat (150) @(posedge clk_sys);
    bus(1'b0, 5'h08, 32'h0);
    chk("hold", 3'h3, d[2:0]);
    wait_mode(3'h1, 100);
    chk("fallback", 1'b1, d[7]);
    arst_n <= 1'b0;
    strap <= 1'b1;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    wait_mode(3'h2, 40);
    chk("run", 4'b1011, {lr, ld, cm, ex});
    mode_cmd(3'h1);
    chk("erase", 1, n_ep);
    wrap_up;
  end
endmodule // scmc_core_bench

//--- scmc_core_properties.sv
/* checker of the mode controller outputs.
   assumes it is bound to scmc_core. */
`timescale 1ns/10ps
module scmc_props (
  input wire clk_sys,
  input wire arst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire led_run,
  input wire led_dbg,
  input wire selftest_run,
  input wire safety_comm_en,
  input wire prog_exec_en,
  input wire app_edit_en,
  input wire safe_in_recv,
  input wire std_in_recv,
  input wire out_clear,
  input wire status_clear,
  input wire status_refresh,
  input wire force_active,
  input wire var_init,
  input wire prog_restart,
  input wire force_clear,
  input wire sio_image_zero,
  input wire nvm_erase_prog,
  input wire nvm_erase_app
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("no answer");
  chk_init_state: assert property (selftest_run |-> !led_dbg &&
    !safe_in_recv && !std_in_recv && out_clear && status_clear)
    else $error("init outputs");
  chk_prog_halt: assert property (app_edit_en |-> !safety_comm_en &&
    !prog_exec_en && !led_dbg && out_clear && !std_in_recv && status_refresh)
    else $error("program outputs");
  chk_comm_refresh: assert property (safety_comm_en |-> safe_in_recv &&
    std_in_recv && !out_clear && status_refresh) else $error("refresh");
  chk_status_excl: assert property (status_clear ^ status_refresh)
    else $error("status word");
  chk_exec_led: assert property (prog_exec_en |-> led_run &&
    safety_comm_en) else $error("exec led");
  chk_dbg_comm: assert property (led_dbg && !status_clear |->
    safety_comm_en && !app_edit_en) else $error("debug comm");
  chk_force_dbg: assert property (force_active |-> led_dbg &&
    !status_clear) else $error("force outside debug");
  chk_force_clr: assert property (force_clear |-> !force_active)
    else $error("force kept");
  chk_restart_pulse: assert property (prog_restart |-> var_init &&
    prog_exec_en ##1 !prog_restart) else $error("restart");
  chk_zero_prog: assert property (sio_image_zero |-> app_edit_en &&
    !safety_comm_en) else $error("image zero");
  chk_erase_prog: assert property (nvm_erase_prog |-> app_edit_en &&
    var_init) else $error("erase prog");
  chk_erase_app: assert property (nvm_erase_app |-> led_dbg &&
    !led_run && safety_comm_en) else $error("erase app");
  chk_restore_mode: assert property (!safety_comm_en && !app_edit_en &&
    !selftest_run |-> status_clear && out_clear) else $error("restore");
endmodule // scmc_props
bind scmc_core scmc_props chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .led_run(led_run), .led_dbg(led_dbg),
  .selftest_run(selftest_run), .safety_comm_en(safety_comm_en),
  .prog_exec_en(prog_exec_en), .app_edit_en(app_edit_en),
  .safe_in_recv(safe_in_recv), .std_in_recv(std_in_recv),
  .out_clear(out_clear), .status_clear(status_clear),
  .status_refresh(status_refresh), .force_active(force_active),
  .var_init(var_init), .prog_restart(prog_restart),
  .force_clear(force_clear), .sio_image_zero(sio_image_zero),
  .nvm_erase_prog(nvm_erase_prog), .nvm_erase_app(nvm_erase_app));

//--- scmc_far_model.sv
/* far side model: tool cable, self-test and validation strap.
   assumes the controller clock and its reset. */
`timescale 1ns/10ps
module scmc_far #(
  parameter int ST_CYC = 30
) (
  input wire clk_sys,
  input wire arst_n,
  input wire cable,
  input wire strap,
  output logic tool_link_ok,
  output logic selftest_done,
  output logic app_valid
);
  int cnt;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      selftest_done <= 1'b0;
    end else if (cnt < ST_CYC) begin
      cnt <= cnt + 1;
    end else begin
      selftest_done <= 1'b1;
    end
  end
  assign tool_link_ok = cable;
  assign app_valid = strap;
endmodule // scmc_far

//--- scmc_regs.vh
/*
 * scmc_regs.vh: register offsets, field positions, reset values,
 * mode codes and timing figures of the safety mode controller.
 * assumes a 20 MHz system clock and a 32-bit avalon-mm slave port.
 */
`ifndef SCMC_REGS_VH
`define SCMC_REGS_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define SCMC_OFS_CMD 5'h00
`define SCMC_OFS_SESSION 5'h04
`define SCMC_OFS_STATUS 5'h08
`define SCMC_OFS_FORCE 5'h0c

// ***************************************************************
// field positions
// ***************************************************************
`define SCMC_CMD_MODE_LSB 0
`define SCMC_CMD_MODE_MSB 2
`define SCMC_SES_OPEN_BIT 0
`define SCMC_SES_CLOSE_BIT 1
`define SCMC_SES_ID_LSB 4
`define SCMC_SES_ID_MSB 7
`define SCMC_ST_MODE_LSB 0
`define SCMC_ST_MODE_MSB 2
`define SCMC_ST_ONLINE_BIT 3
`define SCMC_ST_SREF_BIT 4
`define SCMC_ST_CREJ_BIT 5
`define SCMC_ST_FREJ_BIT 6
`define SCMC_ST_FALLB_BIT 7
`define SCMC_ST_VALID_BIT 8
`define SCMC_FRC_EN_BIT 0

// ***************************************************************
// reset values
// ***************************************************************
`define SCMC_RST_MODE 3'h0
`define SCMC_RST_STICKY 4'h0
`define SCMC_RST_SES_ID 4'h0
`define SCMC_RST_CMD 3'h0

// ***************************************************************
// mode codes
// ***************************************************************
`define SCMC_M_INIT 3'h0
`define SCMC_M_PROG 3'h1
`define SCMC_M_RUN 3'h2
`define SCMC_M_DSTOP 3'h3
`define SCMC_M_DRUN 3'h4
`define SCMC_M_REST 3'h5

// ***************************************************************
// timing
// ***************************************************************
`define SCMC_CLK_KHZ 20000
`define SCMC_TOUT_MS 30000
`define SCMC_BLINK_MS 250
`define SCMC_TOUT_CYC (`SCMC_TOUT_MS * `SCMC_CLK_KHZ)
`define SCMC_BLINK_CYC (`SCMC_BLINK_MS * `SCMC_CLK_KHZ)

`endif

//--- scmc_sync.v
/*
 * scmc_sync.v: three-stage pin synchroniser with agreement filter.
 * assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/10ps

module scmc_sync (
  input wire clk_sys,
  input wire arst_n,
  input wire pin_in,
  output wire level_out
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg lvl_ff;

  // ***************************************************************
  // three flops, change taken when stages two and three agree
  // ***************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign level_out = lvl_ff;

endmodule // scmc_sync

//--- scmc_tmr.v
/*
 * scmc_tmr.v: elapsed-time counter, expires after LIMIT cycles of run.
 * assumes run is a level on the clk_sys domain.
 */
`timescale 1ns/10ps

module scmc_tmr #(
  parameter [29:0] LIMIT = 30'h23c34600
) (
  input wire clk_sys,
  input wire arst_n,
  input wire run,
  output wire expired
);

  reg [29:0] cnt_ff;
  reg exp_ff;
  reg [29:0] nxt_cnt;
  reg nxt_exp;

  // ***************************************************************
  // count while run, clear otherwise
  // ***************************************************************
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (!run) begin
      nxt_cnt = 30'h0;
    end else if (cnt_ff >= LIMIT - 30'h1) begin
      nxt_exp = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 30'h1;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 30'h0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign expired = exp_ff;

endmodule // scmc_tmr
